// >>> sac_pkg.sv
// sac_pkg: constants and types for the converter sequencer control block
// assumes an 8-bit register port with one-cycle read latency
package sac_pkg;

  // register offsets
  localparam logic [7:0] SAC_ADDR_CTRL   = 8'h38;
  localparam logic [7:0] SAC_ADDR_RESULT = 8'h39;
  localparam logic [7:0] SAC_ADDR_CLKSEL = 8'h3A;

  // control/status field positions
  localparam int SAC_DONE_BIT = 7;
  localparam int SAC_IRQE_BIT = 6;
  localparam int SAC_CONT_BIT = 5;
  localparam int SAC_SEL_LSB  = 0;
  localparam int SAC_SEL_W    = 5;

  // clock select register field positions
  localparam int SAC_DIV_LSB  = 5;
  localparam int SAC_DIV_W    = 3;
  localparam int SAC_SRC_BIT  = 4;

  // reset values and codes
  localparam logic [4:0] SAC_SEL_OFF     = 5'h1F;
  localparam logic [4:0] SAC_SEL_LAST    = 5'h0E;
  localparam logic [2:0] SAC_DIV_RESET   = 3'h0;
  localparam logic       SAC_SRC_RESET   = 1'b0;
  localparam logic [7:0] SAC_RESULT_RST  = 8'h00;

  // a conversion runs 16 full converter periods past its first tick
  localparam logic [4:0] SAC_CONV_TICKS  = 5'h10;
  localparam int         SAC_NUM_CH      = 15;
  localparam int         SAC_CH_W        = 16;

  typedef enum logic [2:0] {
    SAC_IDLE = 3'b001,
    SAC_CONV = 3'b010,
    SAC_DONE = 3'b100
  } sac_state_t;

  // register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } sac_req_t;

  // port pin shared with the converter
  typedef struct packed {
    logic [SAC_CH_W-1:0] out;
    logic [SAC_CH_W-1:0] oe;
  } sac_pin_t;

endpackage : sac_pkg

// >>> sac_ctrl.sv
// sac_ctrl: sequencer control for an 8-bit successive-approximation converter
// assumes the analog core supplies an 8-bit sample and the port logic
// hands over its data latches and direction bits for 16 shared pins
//
// Summary of operation
// RULE1: control write starts conversion, finishing after 16 to 17 converter clocks.
// RULE2: result is all ones at high reference, zeros at low, linear.
// RULE3: on completion store result, then set flag or request interrupt.
// RULE4: input select field chooses one of 15 channels for the converter.
// RULE5: selected channel pin is forced to input, overriding port logic.
// RULE6: port data or direction writes do not affect selected pin.
// RULE7: port read of selected pin gives zero if direction zero, else latch.
// RULE8: unselected channel pins stay under general-purpose port control.
// RULE9: continuous mode overwrites result every conversion, read or not.
// RULE10: continuous conversions repeat while continuous bit set, stop when cleared.
// RULE11: in continuous mode flag stays set until control write or result read.
// RULE12: with interrupts off flag is read-only, set at end, cleared by access.
// RULE13: with interrupts on, request interrupt after every conversion.
// RULE14: in light sleep converter runs and its interrupt can wake the cpu.
// RULE15: software powers converter down before light sleep if not needed.
// RULE16: deep sleep aborts conversion; conversions resume after leaving it. Code stays idle until the next control write.
// RULE17: software waits one conversion period after deep sleep before trusting.
// RULE18: software avoids channels twelve and fourteen when used as timer clocks.
// RULE19: codes 0-7 port B, 8-14 port D, all ones off, reset all ones.
// RULE20: prescaler divides by 1,2,4,8, or 16 when top bit set.
// RULE21: source bit picks bus clock (1) or oscillator (0); reset oscillator.
// RULE22: pending interrupt cleared by result read or control write.
// RULE23: control write during conversion restarts with new settings.
`timescale 1ns/1ps
module sac_ctrl
  import sac_pkg::*;
(
  // clock and reset
  input  wire logic                clock_i,
  input  wire logic                reset_i,
  input  wire logic                clk_en_i,
  // register port
  input  wire sac_req_t            req_i,
  output logic [7:0]               rdata_o,
  // clock sources: oscillator tick, bus clock always ticks
  input  wire logic                osc_tick_i,
  // low-power states
  input  wire logic                deep_sleep_i,
  // analog core
  input  wire logic [7:0]          sample_i,
  output logic [SAC_SEL_W-1:0]     selected_analog_input_o,
  output logic                     converter_power_o,
  output logic                     sample_hold_o,
  // port logic: B in bits 7:0, D in bits 14:8
  input  wire logic [SAC_CH_W-1:0] port_latch_i,
  input  wire logic [SAC_CH_W-1:0] port_dir_i,
  input  wire logic [SAC_CH_W-1:0] pin_in_i,
  output sac_pin_t                 pin_o,
  output logic [SAC_CH_W-1:0]      port_read_o,
  // interrupt request to cpu, also a wake source
  output logic                     irq_o
);

  logic [SAC_SEL_W-1:0] input_select_field_reg;
  logic                 completion_irq_enable_reg;
  logic                 continuous_mode_bit_reg;
  logic                 conversion_done_flag_reg;
  logic                 irq_pending_reg;
  logic [2:0]           clock_prescaler_field_reg;
  logic                 converter_clock_source_select_reg;
  logic [7:0]           result_reg;
  logic [7:0]           rdata_reg;
  logic [3:0]           div_cnt_reg;
  logic [4:0]           tick_cnt_reg;
  sac_state_t           state_reg;

  logic ctrl_wr;
  logic result_rd;
  logic powered;
  logic src_tick;
  logic conv_tick;
  logic finish;
  logic [3:0] div_mask;

  assign ctrl_wr   = clk_en_i & req_i.wr & (req_i.addr == SAC_ADDR_CTRL);
  assign result_rd = clk_en_i & req_i.rd & (req_i.addr == SAC_ADDR_RESULT);
  assign powered   = (input_select_field_reg != SAC_SEL_OFF);

  // converter clock source and prescaler
  assign src_tick = converter_clock_source_select_reg ? 1'b1
                                                      : osc_tick_i; // see RULE21

  always_comb
  begin
    case (clock_prescaler_field_reg)
      3'h0:    div_mask = 4'h0;
      3'h1:    div_mask = 4'h1;
      3'h2:    div_mask = 4'h3;
      3'h3:    div_mask = 4'h7;
      default: div_mask = 4'hF; // see RULE20
    endcase
  end

  assign conv_tick = src_tick & ((div_cnt_reg & div_mask) == div_mask);

  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
      div_cnt_reg <= 4'h0;
    else if (clk_en_i & src_tick)
      div_cnt_reg <= div_cnt_reg + 4'h1; // see RULE20
  end

  // control/status register
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      input_select_field_reg    <= SAC_SEL_OFF; // see RULE19
      completion_irq_enable_reg <= 1'b0;
      continuous_mode_bit_reg   <= 1'b0;
    end
    else if (ctrl_wr)
    begin
      input_select_field_reg    <= req_i.wdata[SAC_SEL_LSB +: SAC_SEL_W];
      completion_irq_enable_reg <= req_i.wdata[SAC_IRQE_BIT];
      continuous_mode_bit_reg   <= req_i.wdata[SAC_CONT_BIT];
    end
  end

  // clock select register
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      clock_prescaler_field_reg         <= SAC_DIV_RESET;
      converter_clock_source_select_reg <= SAC_SRC_RESET; // see RULE21
    end
    else if (clk_en_i & req_i.wr & (req_i.addr == SAC_ADDR_CLKSEL))
    begin
      clock_prescaler_field_reg <= req_i.wdata[SAC_DIV_LSB +: SAC_DIV_W];
      converter_clock_source_select_reg <= req_i.wdata[SAC_SRC_BIT];
    end
  end

  // conversion sequencer; the deep sleep input aborts and holds idle
  // the first tick only aligns to the free-running divider, so 16 full
  // converter periods follow it and the run lasts 16 to 17 periods
  assign finish = (state_reg == SAC_CONV) & conv_tick &
                  (tick_cnt_reg == SAC_CONV_TICKS); // see RULE1

  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      state_reg    <= SAC_IDLE;
      tick_cnt_reg <= 5'h00;
    end
    else if (clk_en_i)
    begin
      if (deep_sleep_i)
      begin
        state_reg    <= SAC_IDLE; // see RULE16
        tick_cnt_reg <= 5'h00;
      end
      else if (ctrl_wr)
      begin
        // restart with the new settings unless powering off
        state_reg    <= (req_i.wdata[SAC_SEL_LSB +: SAC_SEL_W] == SAC_SEL_OFF)
                        ? SAC_IDLE : SAC_CONV; // see RULE1, RULE23
        tick_cnt_reg <= 5'h00;
      end
      else
      begin
        case (state_reg)
          SAC_IDLE:
            tick_cnt_reg <= 5'h00;
          SAC_CONV:
            if (!powered)
              state_reg <= SAC_IDLE;
            else if (finish)
            begin
              state_reg    <= SAC_DONE;
              tick_cnt_reg <= 5'h00;
            end
            else if (conv_tick)
              tick_cnt_reg <= tick_cnt_reg + 5'h01;
          SAC_DONE:
            // back to back while continuous bit stays set
            state_reg <= (continuous_mode_bit_reg & powered)
                         ? SAC_CONV : SAC_IDLE; // see RULE10
          default:
            state_reg <= SAC_IDLE;
        endcase
      end
    end
  end

  // result capture: the analog core's code is stored as delivered
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
      result_reg <= SAC_RESULT_RST;
    else if (clk_en_i & finish & ~deep_sleep_i & ~ctrl_wr)
      result_reg <= sample_i; // see RULE2, RULE3, RULE9
  end

  // completion flag and interrupt request; a completion beats a clear
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      conversion_done_flag_reg <= 1'b0;
      irq_pending_reg          <= 1'b0;
    end
    else if (clk_en_i)
    begin
      if (state_reg == SAC_DONE & ~completion_irq_enable_reg)
        conversion_done_flag_reg <= 1'b1; // see RULE3, RULE11, RULE12
      else if (ctrl_wr | result_rd)
        conversion_done_flag_reg <= 1'b0; // see RULE12
      if (state_reg == SAC_DONE & completion_irq_enable_reg)
        irq_pending_reg <= 1'b1; // see RULE13, RULE14
      else if (ctrl_wr | result_rd | ~completion_irq_enable_reg)
        irq_pending_reg <= 1'b0; // see RULE22
    end
  end

  assign irq_o = irq_pending_reg; // see RULE14

  // read port, data one cycle after the strobe
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
      rdata_reg <= 8'h00;
    else if (clk_en_i & req_i.rd)
    begin
      case (req_i.addr)
        SAC_ADDR_CTRL:
          rdata_reg <= {conversion_done_flag_reg, completion_irq_enable_reg,
                        continuous_mode_bit_reg, input_select_field_reg};
        SAC_ADDR_RESULT:
          rdata_reg <= result_reg;
        SAC_ADDR_CLKSEL:
          rdata_reg <= {clock_prescaler_field_reg,
                        converter_clock_source_select_reg, 4'h0};
        default:
          rdata_reg <= 8'h00;
      endcase
    end
  end

  assign rdata_o = rdata_reg;

  // analog side
  assign selected_analog_input_o = input_select_field_reg; // see RULE4
  assign converter_power_o       = powered & ~deep_sleep_i; // see RULE16
  assign sample_hold_o           = (state_reg == SAC_CONV);

  // pin sharing, one slice per port pin; pin 15 is not a channel
  genvar g;
  generate
    for (g = 0; g < SAC_CH_W; g++)
    begin : g_pin
      logic taken;
      assign taken = (g < SAC_NUM_CH) &&
                     (input_select_field_reg == 5'(g)); // see RULE4, RULE19
      assign pin_o.oe[g]  = taken ? 1'b0 : port_dir_i[g]; // see RULE5, RULE6
      assign pin_o.out[g] = port_latch_i[g]; // see RULE8
      assign port_read_o[g] = taken
                              ? (port_dir_i[g] & port_latch_i[g]) // see RULE7
                              : (port_dir_i[g] ? port_latch_i[g]
                                               : pin_in_i[g]); // see RULE8
    end
  endgenerate

endmodule : sac_ctrl

// >>> sac_ctrl_chk.sv
// sac_ctrl_chk: port assertions for the converter sequencer control
// assumes one clock domain and a bind onto every sac_ctrl
`timescale 1ns/1ps
module sac_ctrl_chk
  import sac_pkg::*;
(
  // clock, reset and register port
  input wire logic                 clock_i,
  input wire logic                 reset_i,
  input wire logic                 clk_en_i,
  input wire sac_req_t             req_i,
  input wire logic [7:0]           rdata_o,
  // converter and pins
  input wire logic                 deep_sleep_i,
  input wire logic [SAC_SEL_W-1:0] selected_analog_input_o,
  input wire logic                 converter_power_o,
  input wire logic                 sample_hold_o,
  input wire logic [SAC_CH_W-1:0]  port_latch_i,
  input wire logic [SAC_CH_W-1:0]  port_dir_i,
  input wire sac_pin_t             pin_o,
  input wire logic [SAC_CH_W-1:0]  port_read_o,
  input wire logic                 irq_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  logic       wr_ctl;
  logic       rd_res;
  logic [4:0] sel;
  logic [9:0] run_cnt;
  assign wr_ctl = clk_en_i && req_i.wr && req_i.addr == SAC_ADDR_CTRL;
  assign rd_res = clk_en_i && req_i.rd && req_i.addr == SAC_ADDR_RESULT;
  assign sel = selected_analog_input_o;
  // cycles spent converting since the last start
  always_ff @(posedge clock_i or posedge reset_i)
    if (reset_i)
      run_cnt <= '0;
    else if (wr_ctl || !sample_hold_o)
      run_cnt <= '0;
    else if (clk_en_i)
      run_cnt <= run_cnt + 10'h001;
  // idle for two cycles, so no completion is about to land
  sequence s_quiet;
    !sample_hold_o [*2];
  endsequence
  a_sel_pin_input: assert property (sel < 15 |-> !pin_o.oe[sel])
    else $error("selected pin still driven");
  a_unsel_port_ctl: assert property (sel != 0 |->
    pin_o.oe[0] == port_dir_i[0] && pin_o.out[0] == port_latch_i[0])
    else $error("unselected pin not under port control");
  a_sel_read_val: assert property (sel < 15 |->
    port_read_o[sel] == (port_dir_i[sel] && port_latch_i[sel]))
    else $error("selected pin read wrong");
  a_power_off: assert property (
    sel == SAC_SEL_OFF |-> !converter_power_o)
    else $error("converter powered while off");
  a_deep_abort: assert property (
    deep_sleep_i && clk_en_i |=> !sample_hold_o)
    else $error("conversion not aborted");
  a_start_conv: assert property (
    wr_ctl && req_i.wdata[4:0] != SAC_SEL_OFF && !deep_sleep_i
    |=> sample_hold_o)
    else $error("control write did not start");
  a_conv_length: assert property ($fell(sample_hold_o) &&
    !$past(wr_ctl) && !$past(deep_sleep_i) |-> run_cnt >= 10'd17)
    else $error("conversion too short");
  a_irq_clear: assert property (
    s_quiet ##0 (rd_res || wr_ctl) |=> !irq_o)
    else $error("request not cleared");
  a_unmapped_zero: assert property (
    clk_en_i && req_i.rd && req_i.addr > SAC_ADDR_CLKSEL |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
endmodule : sac_ctrl_chk

bind sac_ctrl sac_ctrl_chk u_chk (.clock_i, .reset_i, .clk_en_i, .req_i,
  .rdata_o, .deep_sleep_i, .selected_analog_input_o, .converter_power_o,
  .sample_hold_o, .port_latch_i, .port_dir_i, .pin_o, .port_read_o, .irq_o);

// >>> sac_pin_model.sv
// sac_pin_model: the shared port pins as seen from outside the chip
// assumes pin_o of sac_ctrl; a released pin floats and wanders
`timescale 1ns/1ps
module sac_pin_model
  import sac_pkg::*;
(
  // clock and pin drive
  input  wire logic            clock_i,
  input  wire sac_pin_t        pin_i,
  // resolved pin levels
  output logic [SAC_CH_W-1:0]  level_o
);
  logic [SAC_CH_W-1:0] float_reg = 16'h5A5A;
  always @(posedge clock_i)
    float_reg <= ~float_reg;
  assign level_o = (pin_i.oe & pin_i.out) | (~pin_i.oe & float_reg);
endmodule : sac_pin_model

// >>> sac_ctrl_tb.sv
// sac_ctrl_tb: self-checking bench for the sequencer control
// assumes sac_ctrl with its bound checker and sac_pin_model on the pins
`timescale 1ns/1ps
module sac_ctrl_tb;
  import sac_pkg::*;
  logic                clock_i = 1'b0;
  logic                reset_i = 1'b1;
  logic                osc = 1'b0;
  logic                deep = 1'b0;
  logic                en = 1'b1;
  logic [7:0]          sample = 8'h00;
  logic [SAC_CH_W-1:0] latch = 16'h0000;
  logic [SAC_CH_W-1:0] dir = 16'h0000;
  logic [SAC_CH_W-1:0] level, port_rd;
  logic [7:0]          rdata;
  logic [4:0]          sel;
  logic                power, hold, irq;
  sac_pin_t            pin;
  sac_req_t            req = '0;
  int                  err_total = 0;
  int                  tests_run = 0;
  int                  cyc;
  always #5 clock_i = ~clock_i;
  always @(posedge clock_i) osc <= ~osc;
  sac_ctrl u_dut (.clock_i(clock_i), .reset_i(reset_i), .clk_en_i(en),
    .req_i(req), .rdata_o(rdata), .osc_tick_i(osc), .deep_sleep_i(deep),
    .sample_i(sample), .selected_analog_input_o(sel),
    .converter_power_o(power), .sample_hold_o(hold), .port_latch_i(latch),
    .port_dir_i(dir), .pin_in_i(level), .pin_o(pin), .port_read_o(port_rd),
    .irq_o(irq));
  sac_pin_model u_pins (.clock_i(clock_i), .pin_i(pin), .level_o(level));
  task automatic stop_test;
    if (err_total == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      $display("BAD %0t got %h want %h", $time, got, exp);
      err_total++;
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i) req <= '{a, d, 1'b1, 1'b0};
    @(posedge clock_i) req.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock_i) req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clock_i) req.rd <= 1'b0;
    #1 chk({8'h00, rdata}, {8'h00, exp});
  endtask : rd
  // waits out a running conversion, then lets flag and request land
  task automatic wait_done;
    cyc = 0;
    #1;
    while (hold === 1'b1 && cyc < 4000)
    begin
      @(posedge clock_i) #1;
      cyc++;
    end
    if (cyc >= 4000)
    begin
      $display("BAD %0t conversion never ended", $time);
      err_total++;
      stop_test;
    end
    repeat (2) @(posedge clock_i);
  endtask : wait_done
  task automatic t_reset;
    rd(SAC_ADDR_CTRL, 8'h1F);
    rd(SAC_ADDR_CLKSEL, 8'h00);
    rd(8'h50, 8'h00);
    chk(power, 1'b0);
  endtask : t_reset
  task automatic t_div;
    int cfg [7] = '{8'h10, 8'h30, 8'h50, 8'h70, 8'h90, 8'hF0, 8'h00};
    int fac [7] = '{1, 2, 4, 8, 16, 16, 2};
    for (int i = 0; i < 7; i++)
    begin
      wr(SAC_ADDR_CLKSEL, 8'(cfg[i]));
      sample <= (i % 2) ? 8'h00 : 8'hFF;
      wr(SAC_ADDR_CTRL, 8'(i));
      wait_done;
      chk(16'(cyc >= 16 * fac[i] && cyc <= 17 * fac[i]), 16'h1);
      chk(16'(sel), 16'(i));
      rd(SAC_ADDR_CTRL, 8'h80 | 8'(i));
      rd(SAC_ADDR_RESULT, (i % 2) ? 8'h00 : 8'hFF);
      rd(SAC_ADDR_CTRL, 8'(i));
    end
  endtask : t_div
  task automatic t_irq;
    wr(SAC_ADDR_CLKSEL, 8'h10);
    wr(SAC_ADDR_CTRL, 8'h48);
    wait_done;
    chk(irq, 1'b1);
    rd(SAC_ADDR_CTRL, 8'h48);
    rd(SAC_ADDR_RESULT, sample);
    chk(irq, 1'b0);
    wr(SAC_ADDR_CTRL, 8'h48);
    wait_done;
    wr(SAC_ADDR_CTRL, 8'h5F);
    #1 chk(irq, 1'b0);
    chk(power, 1'b0);
  endtask : t_irq
  task automatic t_cont;
    sample <= 8'hA5;
    wr(SAC_ADDR_CTRL, 8'h25);
    wait_done;
    sample <= 8'h5A;
    chk(hold, 1'b1);
    wait_done;
    rd(SAC_ADDR_CTRL, 8'hA5);
    rd(SAC_ADDR_RESULT, 8'h5A);
    wr(SAC_ADDR_CTRL, 8'h05);
    wait_done;
    repeat (30) @(posedge clock_i);
    chk(hold, 1'b0);
  endtask : t_cont
  task automatic t_pins;
    @(posedge clock_i) latch <= 16'hAAAA;
    dir <= 16'hFFFF;
    wr(SAC_ADDR_CTRL, 8'h0B);
    #1 chk(pin.oe, 16'hF7FF);
    chk(port_rd & 16'h0800, 16'h0800);
    @(posedge clock_i) dir <= 16'h7FFF;
    latch <= 16'h2AAA;
    #1 chk(pin.oe, 16'h77FF);
    chk(pin.out & 16'hF7FF, 16'h22AA);
    @(posedge clock_i) dir <= 16'h0000;
    #1 chk(port_rd & 16'h0800, 16'h0000);
    chk(port_rd & 16'hF7FF, level & 16'hF7FF);
  endtask : t_pins
  task automatic t_deep;
    wr(SAC_ADDR_CTRL, 8'h02);
    repeat (5) @(posedge clock_i);
    deep <= 1'b1;
    repeat (2) @(posedge clock_i);
    #1 chk(hold, 1'b0);
    @(posedge clock_i) deep <= 1'b0;
    repeat (20) @(posedge clock_i); // settle one conversion
    sample <= 8'h3C;
    wr(SAC_ADDR_CTRL, 8'h02);
    wait_done;
    rd(SAC_ADDR_RESULT, 8'h3C);
  endtask : t_deep
  // clock enable low freezes the run and drops register writes
  task automatic t_freeze;
    wr(SAC_ADDR_CTRL, 8'h03);
    @(posedge clock_i) en <= 1'b0;
    wr(SAC_ADDR_CTRL, 8'h1F);
    repeat (30) @(posedge clock_i);
    #1 chk(hold, 1'b1);
    @(posedge clock_i) en <= 1'b1;
    wait_done;
    chk(16'(cyc >= 15 && cyc <= 16), 16'h1);
    rd(SAC_ADDR_CTRL, 8'h83);
  endtask : t_freeze
  initial
  begin
    repeat (4) @(posedge clock_i);
    reset_i <= 1'b0;
    t_reset;
    t_div;
    t_irq;
    t_cont;
    t_pins;
    t_deep;
    t_freeze;
    stop_test;
  end
endmodule : sac_ctrl_tb
